// ==== rtl/uds_descriptor_source.sv ====
/*
 * Descriptor byte source for enumeration: interrupt IN endpoint
 * descriptor, language string and the three strings, the latter read
 * from an EEPROM when one is fitted, else from fixed fallbacks.
 * Assumes a request side and an EEPROM word reader on CLK; the EEPROM
 * presence strap is an asynchronous pin.
 */
`timescale 1ns/10ps
`include "uds_regs.svh"
module uds_descriptor_source (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic EE_PRESENT,
    input wire logic REQ,
    input wire uds_pkg::uds_sel_t SEL,
    input wire logic [7:0] INDEX,
    output logic BUSY,
    output logic ACK,
    output logic [7:0] DATA,
    output logic PAST_END,
    output logic EE_RD_REQ,
    output logic [7:0] EE_ADDR,
    input wire logic EE_RD_ACK,
    input wire logic [15:0] EE_RD_DATA
);
    import uds_pkg::*;

    uds_main_st_t state_q;
    uds_main_st_t state_d;
    logic ee_meta_q;
    logic ee_sync_q;
    logic ack_q;
    logic [7:0] data_q;
    logic past_q;
    logic start_q;
    logic [1:0] str_q;
    logic [7:0] idx_q;

    uds_eep_if eep ();

    logic [15:0] prod_char [`UDS_STR2_NCHAR];
    logic [7:0] body_ofs_w;
    logic [7:0] char_idx_w;
    logic [15:0] prod_word_w;
    logic [7:0] fixed_byte_w;
    logic [7:0] fixed_len_w;
    logic fixed_past_w;
    logic sel_string_w;
    logic use_eeprom_w;
    logic sel_valid_w;

    // fallback product characters, one per UTF-16 code unit
    assign prod_char[0] = `UDS_STR2_C0;
    assign prod_char[1] = `UDS_STR2_C1;
    assign prod_char[2] = `UDS_STR2_C2;
    assign prod_char[3] = `UDS_STR2_C3;
    assign prod_char[4] = `UDS_STR2_C4;
    assign prod_char[5] = `UDS_STR2_C5;
    assign prod_char[6] = `UDS_STR2_C6;

    assign body_ofs_w = INDEX - `UDS_OFS_BODY;
    assign char_idx_w = {1'b0, body_ofs_w[7:1]};
    assign prod_word_w = (char_idx_w < 8'(`UDS_STR2_NCHAR))
                         ? prod_char[char_idx_w[2:0]] : 16'h0000;

    assign sel_valid_w = (SEL == UDS_SEL_EP3) || (SEL == UDS_SEL_STR0) ||
                         (SEL == UDS_SEL_STR1) || (SEL == UDS_SEL_STR2) ||
                         (SEL == UDS_SEL_STR3);
    assign sel_string_w = (SEL == UDS_SEL_STR1) || (SEL == UDS_SEL_STR2) ||
                          (SEL == UDS_SEL_STR3);
    // string zero never goes to the EEPROM
    assign use_eeprom_w = sel_string_w && ee_sync_q;

    always_comb begin
        fixed_len_w = 8'h00;
        unique case (SEL)
            UDS_SEL_EP3: fixed_len_w = `UDS_EP3_LEN;
            UDS_SEL_STR0: fixed_len_w = `UDS_STR0_LEN;
            UDS_SEL_STR1: fixed_len_w = `UDS_STR1_LEN;
            UDS_SEL_STR2: fixed_len_w = `UDS_STR2_LEN;
            UDS_SEL_STR3: fixed_len_w = `UDS_STR3_LEN;
            default: fixed_len_w = 8'h00;
        endcase
    end

    assign fixed_past_w = !sel_valid_w || (INDEX >= fixed_len_w);

    // endpoint bytes, low byte of the packet size first
    function automatic logic [7:0] ep3_byte(input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            `UDS_OFS_LEN: b = `UDS_EP3_LEN;
            `UDS_OFS_TYPE: b = `UDS_TYPE_ENDPOINT;
            `UDS_OFS_ADDR: b = `UDS_EP3_ADDR;
            `UDS_OFS_ATTR: b = `UDS_EP3_ATTR;
            `UDS_OFS_MPS_LO: b = 8'(`UDS_EP3_MPS);
            `UDS_OFS_MPS_HI: b = 8'(`UDS_EP3_MPS >> 8);
            `UDS_OFS_INTERVAL: b = `UDS_EP3_INTERVAL;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // two-byte-body string: length, type, body low, body high
    function automatic logic [7:0] short_str(input logic [7:0] len,
                                              input logic [15:0] body,
                                              input logic [7:0] i);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            8'h00: b = len;
            8'h01: b = `UDS_TYPE_STRING;
            8'h02: b = body[7:0];
            8'h03: b = body[15:8];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    always_comb begin
        fixed_byte_w = 8'h00;
        unique case (SEL)
            UDS_SEL_EP3: fixed_byte_w = ep3_byte(INDEX);
            UDS_SEL_STR0:
                fixed_byte_w = short_str(`UDS_STR0_LEN, `UDS_LANGID,
                                         INDEX);
            UDS_SEL_STR1:
                fixed_byte_w = short_str(`UDS_STR1_LEN, `UDS_STR1_CHAR,
                                         INDEX);
            UDS_SEL_STR3:
                fixed_byte_w = short_str(`UDS_STR3_LEN, `UDS_STR3_CHAR,
                                         INDEX);
            UDS_SEL_STR2: begin
                if (INDEX == `UDS_OFS_LEN) begin
                    fixed_byte_w = `UDS_STR2_LEN;
                end else if (INDEX == `UDS_OFS_TYPE) begin
                    fixed_byte_w = `UDS_TYPE_STRING;
                end else if (INDEX < `UDS_STR2_LEN) begin
                    fixed_byte_w = body_ofs_w[0] ? prod_word_w[15:8]
                                                 : prod_word_w[7:0];
                end else begin
                    fixed_byte_w = 8'h00;
                end
            end
            default: fixed_byte_w = 8'h00;
        endcase
    end

    // request handshake: one outstanding request at a time
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            UDS_ST_IDLE: begin
                if (REQ) begin
                    state_d = use_eeprom_w ? UDS_ST_EEWAIT : UDS_ST_ANSWER;
                end
            end
            UDS_ST_ANSWER: state_d = UDS_ST_IDLE;
            UDS_ST_EEWAIT: begin
                if (eep.done) begin
                    state_d = UDS_ST_IDLE;
                end
            end
        endcase
    end

    assign BUSY = (state_q != UDS_ST_IDLE);
    assign ACK = ack_q;
    assign DATA = data_q;
    assign PAST_END = past_q;

    assign eep.start = start_q;
    assign eep.str_id = str_q;
    assign eep.byte_idx = idx_q;

    // strap may change at any time; it is only looked at when a request
    // is taken, so a change mid-string mixes sources
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ee_meta_q <= 1'b0;
            ee_sync_q <= 1'b0;
        end else begin
            ee_meta_q <= EE_PRESENT;
            ee_sync_q <= ee_meta_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_q <= UDS_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            start_q <= 1'b0;
            str_q <= 2'h0;
            idx_q <= 8'h00;
        end else begin
            start_q <= (state_q == UDS_ST_IDLE) && REQ && use_eeprom_w;
            if ((state_q == UDS_ST_IDLE) && REQ) begin
                str_q <= SEL[1:0];
                idx_q <= INDEX;
            end
        end
    end

    // EEPROM strings carry their own length, so no end check there
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ack_q <= 1'b0;
            data_q <= 8'h00;
            past_q <= 1'b0;
        end else begin
            ack_q <= 1'b0;
            if ((state_q == UDS_ST_IDLE) && REQ && !use_eeprom_w) begin
                ack_q <= 1'b1;
                data_q <= fixed_byte_w;
                past_q <= fixed_past_w;
            end else if ((state_q == UDS_ST_EEWAIT) && eep.done) begin
                ack_q <= 1'b1;
                data_q <= eep.byte_val;
                past_q <= 1'b0;
            end
        end
    end

    uds_eep_reader u_reader (
        .clk(CLK),
        .resetn(RESETN),
        .req(eep),
        .ee_rd_req(EE_RD_REQ),
        .ee_addr(EE_ADDR),
        .ee_rd_ack(EE_RD_ACK),
        .ee_rd_data(EE_RD_DATA)
    );
endmodule

// ==== rtl/uds_eep_if.sv ====
/*
 * Carrier between the descriptor source and its EEPROM string reader.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface uds_eep_if;
    logic start;
    logic [1:0] str_id;
    logic [7:0] byte_idx;
    logic done;
    logic [7:0] byte_val;

    modport src (output start, output str_id, output byte_idx,
                 input done, input byte_val);
    modport rdr (input start, input str_id, input byte_idx,
                 output done, output byte_val);
endinterface

// ==== rtl/uds_eep_reader.sv ====
/*
 * Fetches one byte of an EEPROM string: reads the pointer word, then the
 * word holding the byte. Assumes an EEPROM word reader on the same clock
 * answering each held request with a one-cycle acknowledge.
 */
`timescale 1ns/10ps
`include "uds_regs.svh"
module uds_eep_reader (
    input wire logic clk,
    input wire logic resetn,
    uds_eep_if.rdr req,
    output logic ee_rd_req,
    output logic [7:0] ee_addr,
    input wire logic ee_rd_ack,
    input wire logic [15:0] ee_rd_data
);
    import uds_pkg::*;

    uds_rd_st_t state_q;
    logic [7:0] addr_q;
    logic [7:0] idx_q;
    logic done_q;
    logic [7:0] byte_q;
    logic [7:0] ptr_w;
    logic [7:0] word_addr_w;

    // selector low bits: 2 maker (word 8), 3 product (9), 0 serial (10)
    assign ptr_w = (req.str_id == 2'h2) ? `UDS_PTR_MFG :
                   (req.str_id == 2'h3) ? `UDS_PTR_PROD :
                   `UDS_PTR_SER;
    // byte k sits in word ptr+k/2, low byte first
    assign word_addr_w = ee_rd_data[7:0] + {1'b0, idx_q[7:1]};

    assign ee_rd_req = (state_q != UDS_RD_IDLE);
    assign ee_addr = addr_q;
    assign req.done = done_q;
    assign req.byte_val = byte_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= UDS_RD_IDLE;
            addr_q <= 8'h00;
            idx_q <= 8'h00;
            done_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                UDS_RD_IDLE: begin
                    if (req.start) begin
                        addr_q <= ptr_w;
                        idx_q <= req.byte_idx;
                        state_q <= UDS_RD_PTR;
                    end
                end
                UDS_RD_PTR: begin
                    if (ee_rd_ack) begin
                        addr_q <= word_addr_w;
                        state_q <= UDS_RD_DATA;
                    end
                end
                UDS_RD_DATA: begin
                    if (ee_rd_ack) begin
                        byte_q <= idx_q[0] ? ee_rd_data[15:8]
                                           : ee_rd_data[7:0];
                        done_q <= 1'b1;
                        state_q <= UDS_RD_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ==== rtl/uds_pkg.sv ====
/*
 * Types of the descriptor source: descriptor selector and state codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uds_pkg;

    typedef enum logic [2:0] {
        UDS_SEL_EP3,
        UDS_SEL_STR0,
        UDS_SEL_STR1,
        UDS_SEL_STR2,
        UDS_SEL_STR3
    } uds_sel_t;

    typedef enum {
        UDS_ST_IDLE,
        UDS_ST_ANSWER,
        UDS_ST_EEWAIT
    } uds_main_st_t;

    typedef enum {
        UDS_RD_IDLE,
        UDS_RD_PTR,
        UDS_RD_DATA
    } uds_rd_st_t;

endpackage

// ==== rtl/uds_regs.svh ====
/*
 * Constants of the descriptor source: descriptor lengths, type codes,
 * field values, EEPROM pointer word addresses and field positions.
 * Assumes inclusion by bare name from the rtl/ directory.
 */
`ifndef UDS_REGS_SVH
`define UDS_REGS_SVH

// descriptor type codes
`define UDS_TYPE_ENDPOINT 8'h05
`define UDS_TYPE_STRING 8'h03

// interrupt IN endpoint descriptor
`define UDS_EP3_LEN 8'h07
`define UDS_EP3_ADDR 8'h83
`define UDS_EP3_NUM_LSB 0
`define UDS_EP3_NUM_MSB 3
`define UDS_EP3_DIR_BIT 7
`define UDS_EP3_ATTR 8'h03
`define UDS_EP3_MPS 16'h0008
`define UDS_EP3_INTERVAL 8'h01

// byte offsets inside the endpoint and string descriptors
`define UDS_OFS_LEN 8'h00
`define UDS_OFS_TYPE 8'h01
`define UDS_OFS_ADDR 8'h02
`define UDS_OFS_ATTR 8'h03
`define UDS_OFS_MPS_LO 8'h04
`define UDS_OFS_MPS_HI 8'h05
`define UDS_OFS_INTERVAL 8'h06
`define UDS_OFS_BODY 8'h02

// language table string
`define UDS_STR0_LEN 8'h04
`define UDS_LANGID 16'h0409

// fallback strings when no EEPROM is fitted
`define UDS_STR1_LEN 8'h04
`define UDS_STR1_CHAR 16'h0020
`define UDS_STR3_LEN 8'h04
`define UDS_STR3_CHAR 16'h0031
`define UDS_STR2_LEN 8'h10
`define UDS_STR2_NCHAR 7
`define UDS_STR2_C0 16'h0055
`define UDS_STR2_C1 16'h0053
`define UDS_STR2_C2 16'h0042
`define UDS_STR2_C3 16'h0020
`define UDS_STR2_C4 16'h0045
`define UDS_STR2_C5 16'h0074
`define UDS_STR2_C6 16'h0068

// EEPROM pointer word addresses
`define UDS_PTR_MFG 8'h08
`define UDS_PTR_PROD 8'h09
`define UDS_PTR_SER 8'h0A

`endif

// ==== test/uds_descriptor_source_asserts.sv ====
/*
 * Concurrent checks on the descriptor source top ports.
 * Assumes binding to uds_descriptor_source, one clock domain.
 */
`timescale 1ns/10ps
module uds_descriptor_source_asserts
    import uds_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic EE_PRESENT,
    input wire logic REQ,
    input wire uds_pkg::uds_sel_t SEL,
    input wire logic [7:0] INDEX,
    input wire logic BUSY,
    input wire logic ACK,
    input wire logic [7:0] DATA,
    input wire logic PAST_END,
    input wire logic EE_RD_REQ,
    input wire logic [7:0] EE_ADDR,
    input wire logic EE_RD_ACK,
    input wire logic [15:0] EE_RD_DATA
);
    logic [3:0] hist_q;
    logic [15:0] word_q;
    logic odd_q;
    logic eep_q;
    wire take = REQ && !BUSY;
    // strap must sit still past the synchroniser before we judge
    wire ee_on = EE_PRESENT && (&hist_q);
    wire ee_off = !EE_PRESENT && !(|hist_q);
    wire str_sel = SEL inside {UDS_SEL_STR1, UDS_SEL_STR2, UDS_SEL_STR3};
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            hist_q <= 4'h0;
            word_q <= 16'h0000;
            odd_q <= 1'b0;
            eep_q <= 1'b0;
        end else begin
            hist_q <= {hist_q[2:0], EE_PRESENT};
            if (EE_RD_REQ && EE_RD_ACK) word_q <= EE_RD_DATA;
            if (take) odd_q <= INDEX[0];
            if (take) eep_q <= ee_on && str_sel;
            else if (ACK) eep_q <= 1'b0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_take(uds_sel_t s, logic [7:0] i);
        take && SEL == s && INDEX == i;
    endsequence
    property p_byte(uds_sel_t s, logic [7:0] i, logic [7:0] v);
        s_take(s, i) |=> ACK && DATA == v && !PAST_END;
    endproperty
    property p_dflt(uds_sel_t s, logic [7:0] i, logic [7:0] v);
        ee_off ##0 s_take(s, i) |=> ACK && DATA == v && !PAST_END;
    endproperty
    a_ep3_len: assert property (p_byte(UDS_SEL_EP3, 8'h00, 8'h07))
        else $error("endpoint length byte wrong");
    a_ep3_type: assert property (p_byte(UDS_SEL_EP3, 8'h01, 8'h05))
        else $error("endpoint type byte wrong");
    a_ep3_addr: assert property (p_byte(UDS_SEL_EP3, 8'h02, 8'h83))
        else $error("endpoint address byte wrong");
    a_ep3_attr: assert property (p_byte(UDS_SEL_EP3, 8'h03, 8'h03))
        else $error("endpoint attribute byte wrong");
    a_ep3_intvl: assert property (p_byte(UDS_SEL_EP3, 8'h06, 8'h01))
        else $error("endpoint interval byte wrong");
    a_ep3_mps: assert property (p_byte(UDS_SEL_EP3, 8'h04, 8'h08))
        else $error("endpoint packet size byte wrong");
    a_lang_id: assert property (p_byte(UDS_SEL_STR0, 8'h02, 8'h09))
        else $error("language id byte wrong");
    a_mfg_dflt: assert property (p_dflt(UDS_SEL_STR1, 8'h02, 8'h20))
        else $error("fallback maker char wrong");
    a_ser_dflt: assert property (p_dflt(UDS_SEL_STR3, 8'h02, 8'h31))
        else $error("fallback serial char wrong");
    a_prod_len: assert property (p_dflt(UDS_SEL_STR2, 8'h00, 8'h10))
        else $error("fallback product length wrong");
    a_ptr_word: assert property (ee_on && take && SEL == UDS_SEL_STR2
        |-> ##[1:3] (EE_RD_REQ && EE_ADDR == 8'h09))
        else $error("product pointer word not read");
    a_eep_byte: assert property (ACK && eep_q |-> !PAST_END &&
        DATA == (odd_q ? word_q[15:8] : word_q[7:0]))
        else $error("eeprom string byte wrong");
endmodule

// ==== test/uds_descriptor_source_tb.sv ====
/*
 * Self-checking bench for the descriptor source.
 * Assumes the EEPROM model and checker files are compiled before it.
 */
`timescale 1ns/10ps
module uds_descriptor_source_tb;
    import uds_pkg::*;
    logic CLK = 0, RESETN = 0, EE_PRESENT = 0, REQ = 0, slow = 0;
    uds_sel_t SEL = UDS_SEL_EP3;
    logic [7:0] INDEX = 8'h00, DATA, EE_ADDR;
    logic BUSY, ACK, PAST_END, EE_RD_REQ, EE_RD_ACK;
    logic [15:0] EE_RD_DATA;
    int fail_count = 0, check_count = 0;
    always #5 CLK = ~CLK;
    uds_descriptor_source dut_u (.CLK(CLK), .RESETN(RESETN),
        .EE_PRESENT(EE_PRESENT), .REQ(REQ), .SEL(SEL), .INDEX(INDEX),
        .BUSY(BUSY), .ACK(ACK), .DATA(DATA), .PAST_END(PAST_END),
        .EE_RD_REQ(EE_RD_REQ), .EE_ADDR(EE_ADDR),
        .EE_RD_ACK(EE_RD_ACK), .EE_RD_DATA(EE_RD_DATA));
    uds_eep_model eep_u (.clk(CLK), .resetn(RESETN), .slow(slow),
        .ee_rd_req(EE_RD_REQ), .ee_addr(EE_ADDR),
        .ee_rd_ack(EE_RD_ACK), .ee_rd_data(EE_RD_DATA));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset(input int n);
        RESETN = 1'b0;
        repeat (n) @(negedge CLK);
        RESETN = 1'b1;
    endtask
    // one request; REQ goes up only once BUSY is seen low
    task automatic xfer(input uds_sel_t s, input int i, output logic [8:0] r);
        int n;
        n = 0;
        @(negedge CLK);
        while (BUSY !== 1'b0 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        SEL = s;
        INDEX = 8'(i);
        REQ = 1'b1;
        @(negedge CLK);
        REQ = 1'b0;
        while (ACK !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        if (n >= 100) fail_count++;
        r = {PAST_END, DATA};
    endtask
    task automatic t_ep3;
        logic [7:0] tab [0:7] = '{8'h07, 8'h05, 8'h83, 8'h03,
            8'h08, 8'h00, 8'h01, 8'h00};
        logic [8:0] r;
        for (int i = 0; i < 8; i++) begin
            xfer(UDS_SEL_EP3, i, r);
            check(r, {i == 7, tab[i]});
        end
        $display("test ep3 done");
    endtask
    task automatic t_str0;
        logic [7:0] tab [0:4] = '{8'h04, 8'h03, 8'h09, 8'h04, 8'h00};
        logic [8:0] r;
        for (int i = 0; i < 5; i++) begin
            xfer(UDS_SEL_STR0, i, r);
            check(r, {i == 4, tab[i]});
        end
        $display("test string zero done");
    endtask
    task automatic t_fallback;
        logic [7:0] prod [0:15] = '{8'h10, 8'h03, 8'h55, 8'h00, 8'h53,
            8'h00, 8'h42, 8'h00, 8'h20, 8'h00, 8'h45, 8'h00, 8'h74,
            8'h00, 8'h68, 8'h00};
        logic [7:0] mfg [0:3] = '{8'h04, 8'h03, 8'h20, 8'h00};
        logic [7:0] ser [0:3] = '{8'h04, 8'h03, 8'h31, 8'h00};
        logic [8:0] r;
        for (int i = 0; i <= 16; i++) begin
            xfer(UDS_SEL_STR2, i, r);
            check(r, {i == 16, i < 16 ? prod[i] : 8'h00});
        end
        for (int i = 0; i <= 4; i++) begin
            xfer(UDS_SEL_STR1, i, r);
            check(r, {i == 4, i < 4 ? mfg[i] : 8'h00});
            xfer(UDS_SEL_STR3, i, r);
            check(r, {i == 4, i < 4 ? ser[i] : 8'h00});
        end
        $display("test fallback strings done");
    endtask
    task automatic t_eeprom;
        logic [8:0] r;
        logic [7:0] p;
        logic [7:0] e;
        logic [15:0] w;
        for (int a = 0; a < 256; a++) eep_u.mem[a] = {8'(a) ^ 8'h5A, 8'(a)};
        eep_u.mem[8] = 16'h0020;
        eep_u.mem[9] = 16'h0040;
        eep_u.mem[10] = 16'h0060;
        eep_u.mem[8'h20] = 16'h0306;
        eep_u.mem[8'h40] = 16'h0308;
        eep_u.mem[8'h60] = 16'h0304;
        EE_PRESENT = 1'b1;
        repeat (6) @(negedge CLK);
        for (int s = 1; s <= 3; s++) begin
            // the serial string runs against a slow EEPROM
            slow = (s == 3);
            p = eep_u.mem[7 + s][7:0];
            for (int k = 0; k < eep_u.mem[p][7:0]; k++) begin
                w = eep_u.mem[8'(p + k / 2)];
                xfer(uds_sel_t'(3'(s + 1)), k, r);
                e = (k % 2) ? w[15:8] : w[7:0];
                check(r, {1'b0, e});
            end
        end
        $display("test eeprom strings done");
        t_str0();
    endtask
    initial begin
        do_reset(12);
        t_ep3();
        t_str0();
        t_fallback();
        do_reset(3);
        t_eeprom();
        conclude();
    end
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule
bind uds_descriptor_source uds_descriptor_source_asserts chk_u (
    .CLK(CLK), .RESETN(RESETN), .EE_PRESENT(EE_PRESENT), .REQ(REQ),
    .SEL(SEL), .INDEX(INDEX), .BUSY(BUSY), .ACK(ACK), .DATA(DATA),
    .PAST_END(PAST_END), .EE_RD_REQ(EE_RD_REQ), .EE_ADDR(EE_ADDR),
    .EE_RD_ACK(EE_RD_ACK), .EE_RD_DATA(EE_RD_DATA));

// ==== test/uds_eep_model.sv ====
/*
 * Word-wide EEPROM reader model facing the descriptor source.
 * Assumes the same clock; the bench fills mem before strings are read.
 */
`timescale 1ns/10ps
module uds_eep_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic ee_rd_req,
    input wire logic [7:0] ee_addr,
    output logic ee_rd_ack,
    output logic [15:0] ee_rd_data
);
    logic [15:0] mem [0:255];
    logic [1:0] wait_q;
    wire ready = (wait_q == (slow ? 2'h3 : 2'h0));
    always @(posedge clk) begin
        if (!resetn) begin
            ee_rd_ack <= 1'b0;
            wait_q <= 2'h0;
            ee_rd_data <= 16'hA5A5;
        end else if (ee_rd_req && !ee_rd_ack && ready) begin
            ee_rd_ack <= 1'b1;
            ee_rd_data <= mem[ee_addr];
            wait_q <= 2'h0;
        end else begin
            ee_rd_ack <= 1'b0;
            // word is not held once the acknowledge is gone
            ee_rd_data <= ~ee_rd_data;
            if (ee_rd_req && !ee_rd_ack) begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule
